// [rtl/spi_frame_pkg.sv]
// Shared constants, types and timing counts for the serial port frame logic.
package spi_frame_pkg;

   // ---------------------------------------------------------------------
   // Register map (byte addresses on the plain register port)
   // ---------------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_TXDATA = 8'h04;
   localparam logic [7:0] ADDR_RXDATA = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;

   // ---------------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------------
   localparam int CTRL_EN_BIT     = 0;
   localparam int CTRL_MASTER_BIT = 1;
   localparam int CTRL_CPOL_BIT   = 2;
   localparam int CTRL_CPHA_BIT   = 3;
   localparam int CTRL_SIZE_LSB   = 4;
   localparam int STAT_BUSY_BIT   = 0;
   localparam int STAT_TXFULL_BIT = 1;
   localparam int STAT_RXVAL_BIT  = 2;
   localparam int STAT_SEL_BIT    = 3;
   localparam logic [3:0] SIZE_M1_MIN = 4'h3;
   localparam logic [3:0] SIZE_M1_RST = 4'h7;

   // ---------------------------------------------------------------------
   // Timing: half a bit-clock period, in ns, turned into sys_clk cycles
   // ---------------------------------------------------------------------
   localparam int SYS_CLK_PERIOD_PS  = 5000;
   localparam int SCK_HALF_PERIOD_NS = 100;
   localparam int HALF_CYCLES = (SCK_HALF_PERIOD_NS * 1000
                                 + SYS_CLK_PERIOD_PS - 1) / SYS_CLK_PERIOD_PS;
   localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

   // ---------------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_ACTIVE = 2'b01,
      ST_GAP    = 2'b10
   } mst_state_t;

   typedef struct packed {
      logic [3:0] size_m1;
      logic       cpha;
      logic       cpol;
      logic       master;
      logic       en;
   } cfg_t;

   localparam cfg_t CFG_RESET = '{size_m1: SIZE_M1_RST, cpha: 1'b0,
                                  cpol: 1'b0, master: 1'b0, en: 1'b0};

endpackage

// [rtl/level_sync.sv]
// Three-stage synchroniser that passes a change once stages two and three agree.
`timescale 1ns/1ps

module level_sync #(
   parameter int         W        = 1,
   parameter logic [0:0] RST_VAL  = 1'b0
) (
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;

   // The first stage feeds only the second; nothing else looks at it.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= {W{RST_VAL}};
         s2_reg <= {W{RST_VAL}};
         s3_reg <= {W{RST_VAL}};
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A bit of the output moves only when the last two stages agree.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= {W{RST_VAL}};
      end else begin
         q <= (s2_reg & ~(s2_reg ^ s3_reg)) | (q & (s2_reg ^ s3_reg));
      end
   end

endmodule

// [rtl/spi_frame_port.sv]
// Serial port frame sequencer: master in sys_clk, slave on the link clock.
// Functional notes
// - Idle: frame_select high and serial_out low in every mode.
// - Idle bit clock rests at the level of clock_polarity.
// - Master drives the bit clock pad; slave leaves it as input.
// - Master starts a frame, select low, when enabled with data queued.
// - Master enables its serial_out driver as select falls.
// - Phase 0: first bit half period after select, clock half later.
// - Pol 0 phase 0: sample on rising, change on falling clock.
// - Pol 0 phase 1: clock rises with data; sample falling edges.
// - Pol 1 phase 0: clock falls half after data; sample falling.
// - Pol 1 phase 1: clock first falls; sample on rising edges.
// - Phase 1: both sides drive data half period after select.
// - Select returns high one bit period after last capture.
// - Phase 0 back-to-back words: select pulses high between words.
// - Phase 1 back-to-back: select stays low; burst ends as single.
// - Words of 4 to 16 bits, most significant bit first.
// - Phase 0 captures on first clock transition, phase 1 second.
`timescale 1ns/1ps

module spi_frame_port #(
   parameter int WORD_W = 16
) (
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic [7:0]        addr,
   input  wire logic [31:0]       wdata,
   input  wire logic              wr_stb,
   input  wire logic              rd_stb,
   output logic      [31:0]       rdata,
   input  wire logic              serial_bit_clock_in,
   output logic                   serial_bit_clock_out,
   output logic                   serial_bit_clock_oe_n,
   input  wire logic              frame_select_in,
   output logic                   frame_select_out,
   output logic                   frame_select_oe_n,
   output logic                   serial_out,
   output logic                   serial_out_oe_n,
   input  wire logic              serial_in
);

   // ---------------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------------
   spi_frame_pkg::cfg_t       cfg_reg;
   spi_frame_pkg::mst_state_t state_reg;
   logic [WORD_W-1:0] tx_data_reg;
   logic              tx_valid_reg;
   logic [WORD_W-1:0] rx_data_reg;
   logic              rx_valid_reg;
   logic [31:0]       rdata_reg;
   logic [7:0]        div_reg;
   logic [5:0]        half_reg;
   logic              fs_reg;
   logic              sck_reg;
   logic              sdo_reg;
   logic              sdo_en_reg;
   logic [WORD_W-1:0] tx_shift_reg;
   logic [WORD_W-1:0] rx_shift_reg;
   logic [4:0]        cap_cnt_reg;
   logic              sin_sync;
   logic              sel_sync;
   logic              done_sync;
   logic              done_seen_reg;
   logic [WORD_W-1:0] slv_tx_word_reg;
   // Link-clock domain.
   logic [3:0]        slv_cnt_reg;
   logic [3:0]        slv_launch_reg;
   logic [WORD_W-1:0] slv_rx_shift_reg;
   logic [WORD_W-1:0] slv_rx_hold_reg;
   logic              slv_done_tgl_reg;
   logic              slv_clk;
   logic              slv_rst_n;
   logic [3:0]        slv_idx;
   logic              slv_out;
   // Sequencer decode.
   logic [4:0]        nbits;
   logic [5:0]        two_n;
   logic [5:0]        h_n;
   logic              tick;
   logic              start_ok;
   logic              is_cap;
   logic              is_launch;
   logic              is_toggle;
   logic              restart;
   logic              word_end;
   logic              gap_end;
   logic              mst_load;
   logic              slv_word_done;
   logic              wr_tx_ok;
   logic [WORD_W-1:0] rx_shift_next;

   // ---------------------------------------------------------------------
   // Register port
   // ---------------------------------------------------------------------

   // Control word; a size below four bits is clamped so a frame never
   // collapses to nothing.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_reg <= spi_frame_pkg::CFG_RESET;
      end else if (wr_stb && addr == spi_frame_pkg::ADDR_CTRL) begin
         cfg_reg.en      <= wdata[spi_frame_pkg::CTRL_EN_BIT];
         cfg_reg.master  <= wdata[spi_frame_pkg::CTRL_MASTER_BIT];
         cfg_reg.cpol    <= wdata[spi_frame_pkg::CTRL_CPOL_BIT];
         cfg_reg.cpha    <= wdata[spi_frame_pkg::CTRL_CPHA_BIT];
         cfg_reg.size_m1 <=
            (wdata[spi_frame_pkg::CTRL_SIZE_LSB +: 4]
             < spi_frame_pkg::SIZE_M1_MIN) ? spi_frame_pkg::SIZE_M1_MIN
                                           : wdata[spi_frame_pkg::CTRL_SIZE_LSB +: 4];
      end
   end

   // One transmit word is held; a write while full is dropped unless the
   // word is consumed in that same cycle, in which case the write wins.
   assign wr_tx_ok = wr_stb && addr == spi_frame_pkg::ADDR_TXDATA
                     && (!tx_valid_reg || mst_load || slv_word_done);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_data_reg  <= '0;
         tx_valid_reg <= 1'b0;
      end else if (wr_tx_ok) begin
         tx_data_reg  <= wdata[WORD_W-1:0];
         tx_valid_reg <= 1'b1;
      end else if (mst_load || slv_word_done) begin
         tx_valid_reg <= 1'b0;
      end
   end

   // Read data appears in the cycle after the strobe; unmapped reads zero.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= '0;
      end else if (rd_stb) begin
         case (addr)
            spi_frame_pkg::ADDR_CTRL:   rdata_reg <= 32'({cfg_reg.size_m1,
                                           cfg_reg.cpha, cfg_reg.cpol,
                                           cfg_reg.master, cfg_reg.en});
            spi_frame_pkg::ADDR_TXDATA: rdata_reg <= 32'(tx_data_reg);
            spi_frame_pkg::ADDR_RXDATA: rdata_reg <= 32'(rx_data_reg);
            spi_frame_pkg::ADDR_STATUS: rdata_reg <= 32'({~sel_sync,
                                           rx_valid_reg, tx_valid_reg,
                                           state_reg != spi_frame_pkg::ST_IDLE});
            default:                    rdata_reg <= 32'h0000_0000;
         endcase
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end
   assign rdata = rdata_reg;

   // Received word store; a new word in the cycle of a data read wins.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_data_reg  <= '0;
         rx_valid_reg <= 1'b0;
      end else if (is_cap && h_n == two_n) begin
         rx_data_reg  <= rx_shift_next;
         rx_valid_reg <= 1'b1;
      end else if (slv_word_done) begin
         rx_data_reg  <= slv_rx_hold_reg;
         rx_valid_reg <= 1'b1;
      end else if (rd_stb && addr == spi_frame_pkg::ADDR_RXDATA) begin
         rx_valid_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------------
   // Master sequencer, counted in half bit-clock periods from select fall
   // ---------------------------------------------------------------------
   always_comb begin
      nbits     = 5'({1'b0, cfg_reg.size_m1}) + 5'h01;
      two_n     = {nbits, 1'b0};
      tick      = (state_reg != spi_frame_pkg::ST_IDLE)
                  && (div_reg == spi_frame_pkg::HALF_LAST);
      h_n       = half_reg + 6'h01;
      start_ok  = cfg_reg.en && cfg_reg.master && tx_valid_reg;
      is_cap    = tick && state_reg == spi_frame_pkg::ST_ACTIVE
                  && !h_n[0] && h_n >= 6'h02 && h_n <= two_n;
      is_launch = tick && state_reg == spi_frame_pkg::ST_ACTIVE
                  && h_n[0] && h_n < two_n;
      is_toggle = tick && state_reg == spi_frame_pkg::ST_ACTIVE
                  && (cfg_reg.cpha ? (h_n <= two_n)
                                   : (h_n >= 6'h02 && h_n <= two_n + 6'h01));
      restart   = tick && state_reg == spi_frame_pkg::ST_ACTIVE
                  && cfg_reg.cpha && h_n == two_n + 6'h01 && start_ok;
      word_end  = tick && state_reg == spi_frame_pkg::ST_ACTIVE
                  && h_n == two_n + 6'h02;
      gap_end   = tick && state_reg == spi_frame_pkg::ST_GAP;
      mst_load  = (state_reg == spi_frame_pkg::ST_IDLE && start_ok)
                  || restart || (gap_end && start_ok);
      rx_shift_next = {rx_shift_reg[WORD_W-2:0], sin_sync};
   end

   // Half-period divider; it restarts at every frame start.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= 8'h00;
      end else if (tick || state_reg == spi_frame_pkg::ST_IDLE) begin
         div_reg <= 8'h00;
      end else begin
         div_reg <= div_reg + 8'h01;
      end
   end

   // Frame state, select and half-period index.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= spi_frame_pkg::ST_IDLE;
         half_reg  <= 6'h00;
         fs_reg    <= 1'b1;
      end else begin
         case (state_reg)
            spi_frame_pkg::ST_IDLE: begin
               if (start_ok) begin
                  state_reg <= spi_frame_pkg::ST_ACTIVE;
                  half_reg  <= 6'h00;
                  fs_reg    <= 1'b0;
               end
            end
            spi_frame_pkg::ST_ACTIVE: begin
               if (restart) begin
                  half_reg <= 6'h01;
               end else if (word_end) begin
                  fs_reg    <= 1'b1;
                  state_reg <= (!cfg_reg.cpha && start_ok)
                               ? spi_frame_pkg::ST_GAP : spi_frame_pkg::ST_IDLE;
               end else if (tick) begin
                  half_reg <= h_n;
               end
            end
            spi_frame_pkg::ST_GAP: begin
               if (gap_end) begin
                  state_reg <= start_ok ? spi_frame_pkg::ST_ACTIVE
                                        : spi_frame_pkg::ST_IDLE;
                  half_reg  <= 6'h00;
                  fs_reg    <= !start_ok;
               end
            end
            default: begin
               state_reg <= spi_frame_pkg::ST_IDLE;
               fs_reg    <= 1'b1;
            end
         endcase
      end
   end

   // Bit clock: rests at the polarity level, toggles only inside frames.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_reg <= 1'b0;
      end else if (state_reg == spi_frame_pkg::ST_IDLE) begin
         sck_reg <= cfg_reg.cpol;
      end else if (is_toggle || restart) begin
         sck_reg <= ~sck_reg;
      end
   end

   // Transmit shifter and serial_out; idle level is low.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sdo_reg      <= 1'b0;
         tx_shift_reg <= '0;
      end else if (restart) begin
         sdo_reg      <= tx_data_reg[cfg_reg.size_m1];
         tx_shift_reg <= tx_data_reg << 1;
      end else if (mst_load) begin
         tx_shift_reg <= tx_data_reg;
      end else if (is_launch) begin
         // first bit half period after select; MSB first
         sdo_reg      <= tx_shift_reg[cfg_reg.size_m1];
         tx_shift_reg <= tx_shift_reg << 1;
      end else if (word_end || state_reg == spi_frame_pkg::ST_IDLE) begin
         sdo_reg <= 1'b0;
      end
   end

   // Output driver enable follows the master frame start.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sdo_en_reg <= 1'b0;
      end else if (!cfg_reg.en || !cfg_reg.master) begin
         sdo_en_reg <= 1'b0;
      end else if (state_reg == spi_frame_pkg::ST_IDLE && start_ok) begin
         sdo_en_reg <= 1'b1;
      end
   end

   // Receive shifter and capture-edge count for the current word.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_shift_reg <= '0;
         cap_cnt_reg  <= 5'h00;
      end else if (is_cap) begin
         // capture on first or second transition
         rx_shift_reg <= rx_shift_next;
         cap_cnt_reg  <= cap_cnt_reg + 5'h01;
      end else if (mst_load) begin
         cap_cnt_reg  <= 5'h00;
      end
   end

   // serial_in is a pin; sampling at the capture tick sees it four cycles
   // late, which is safe while a half period exceeds four sys_clk cycles.
   level_sync #(.W(1), .RST_VAL(1'b0)) u_sin_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .d       (serial_in),
      .q       (sin_sync)
   );

   // ---------------------------------------------------------------------
   // Slave: shifters run on the incoming bit clock
   // ---------------------------------------------------------------------

   // Folding the mode into the clock makes its rising edge the sample edge
   // in all four modes; the mode bits must only change while disabled.
   assign slv_clk   = serial_bit_clock_in ^ (cfg_reg.cpol ^ cfg_reg.cpha);
   assign slv_rst_n = rst_n & ~frame_select_in & cfg_reg.en & ~cfg_reg.master;

   // Sample-edge bit counter; select high clears it.
   always_ff @(posedge slv_clk or negedge slv_rst_n) begin
      if (!slv_rst_n) begin
         slv_cnt_reg      <= 4'h0;
         slv_rx_shift_reg <= '0;
      end else begin
         // slave samples on the capture edge
         slv_rx_shift_reg <= {slv_rx_shift_reg[WORD_W-2:0], serial_in};
         slv_cnt_reg      <= (slv_cnt_reg == cfg_reg.size_m1)
                             ? 4'h0 : slv_cnt_reg + 4'h1;
      end
   end

   // Word hand-off; the toggle survives select so no word is lost.
   always_ff @(posedge slv_clk or negedge rst_n) begin
      if (!rst_n) begin
         slv_rx_hold_reg  <= '0;
         slv_done_tgl_reg <= 1'b0;
      end else if (slv_rst_n && slv_cnt_reg == cfg_reg.size_m1) begin
         slv_rx_hold_reg  <= {slv_rx_shift_reg[WORD_W-2:0], serial_in};
         slv_done_tgl_reg <= ~slv_done_tgl_reg;
      end
   end

   // Launch-edge counter; phase 1 launches before its first sample.
   always_ff @(negedge slv_clk or negedge slv_rst_n) begin
      if (!slv_rst_n) begin
         slv_launch_reg <= 4'h0;
      end else begin
         slv_launch_reg <= (slv_launch_reg == cfg_reg.size_m1)
                           ? 4'h0 : slv_launch_reg + 4'h1;
      end
   end

   // phase 0 MSB present as select falls
   assign slv_idx = cfg_reg.size_m1 - (slv_launch_reg - 4'(cfg_reg.cpha));
   assign slv_out = slv_tx_word_reg[slv_idx];

   // The toggle crosses inverted so both bits rest high out of reset;
   // otherwise the sync would fall after reset and fake a finished word.
   level_sync #(.W(2), .RST_VAL(1'b1)) u_sel_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .d       ({frame_select_in, ~slv_done_tgl_reg}),
      .q       ({sel_sync, done_sync})
   );

   // slave word reloads only while deselected
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         slv_tx_word_reg <= '0;
         done_seen_reg   <= 1'b1;
      end else begin
         done_seen_reg <= done_sync;
         if (sel_sync && tx_valid_reg && !cfg_reg.master) begin
            slv_tx_word_reg <= tx_data_reg;
         end
      end
   end
   assign slv_word_done = (done_sync != done_seen_reg) && !cfg_reg.master;

   // ---------------------------------------------------------------------
   // Pins
   // ---------------------------------------------------------------------
   assign serial_bit_clock_out  = sck_reg;
   assign serial_bit_clock_oe_n = ~cfg_reg.master;
   assign frame_select_out      = fs_reg;
   assign frame_select_oe_n     = ~cfg_reg.master;
   assign serial_out      = cfg_reg.master ? sdo_reg : (slv_out & ~sel_sync);
   assign serial_out_oe_n = cfg_reg.master ? ~sdo_en_reg : sel_sync;

   // ---------------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------------
   idle_pins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(state_reg == spi_frame_pkg::ST_IDLE) && state_reg == spi_frame_pkg::ST_IDLE
      |-> fs_reg && !sdo_reg)
      else $error("idle select or data level wrong");

   idle_clock_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state_reg == spi_frame_pkg::ST_IDLE ##1 state_reg == spi_frame_pkg::ST_IDLE
      |-> sck_reg == $past(cfg_reg.cpol))
      else $error("idle clock not at polarity level");

   pad_dir_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      serial_bit_clock_oe_n == !cfg_reg.master)
      else $error("clock pad direction wrong");

   frame_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state_reg == spi_frame_pkg::ST_IDLE && start_ok |=> !fs_reg && sdo_en_reg)
      else $error("frame did not start");

   first_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $fell(fs_reg) && !cfg_reg.cpha |-> (sck_reg == cfg_reg.cpol)[*8])
      else $error("clock moved too early in phase 0");

   burst_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state_reg == spi_frame_pkg::ST_ACTIVE && $past(state_reg) == spi_frame_pkg::ST_ACTIVE
      |-> !fs_reg)
      else $error("select rose inside a word");

   burst_clock_a: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      restart |=> !fs_reg && sck_reg != $past(sck_reg))
      else $error("burst word did not restart with a clock edge");

   gap_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      word_end && !cfg_reg.cpha && start_ok |=> fs_reg && state_reg == spi_frame_pkg::ST_GAP)
      else $error("no select pulse between words");

   cap_count_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      word_end |-> cap_cnt_reg == nbits && sck_reg == cfg_reg.cpol)
      else $error("capture count or clock end level wrong");

endmodule

// [sim/spi_slave_model.sv]
// Behavioural slave device that answers the master-mode frames.
`timescale 1ns/1ps
module spi_slave_model (
   input  wire logic       sck,
   input  wire logic       fs_n,
   input  wire logic       mosi,
   input  wire logic [1:0] mode,
   input  wire logic [4:0] n,
   output logic            miso,
   output logic [15:0]     rx,
   output int              edges
);
   localparam logic [15:0] WORD = 16'hc3a5;
   int idx;
   initial miso = 1'b0;
   always @(fs_n) begin
      if (fs_n === 1'b0) begin
         idx = mode[1] ? n : n - 1;
         miso = mode[1] ? ~miso : WORD[idx];
         edges = 0;
      end else begin
         miso = ~miso; // A released line must not hold its last value.
      end
   end
   always @(sck) begin
      if (fs_n === 1'b0 && sck === ~(mode[0] ^ mode[1])) begin
         rx = {rx[14:0], mosi};
         edges++;
      end else if (fs_n === 1'b0) begin
         idx = (idx == 0) ? n - 1 : idx - 1;
         miso = WORD[idx];
      end
   end
endmodule

// [sim/spi_frame_port_bench.sv]
// Self-checking bench for the serial port frame sequencer.
`timescale 1ns/1ps
module spi_frame_port_bench;
   localparam logic [4:0] NS [4] = '{5'd4, 5'd8, 5'd16, 5'd5};
   localparam logic [15:0] TXW = 16'h9b6d;
   localparam logic [15:0] SW = 16'hc3a5;
   logic sys_clk, rst_n, wr_stb, rd_stb, sck_o, sck_oe_n, fs_o, fs_oe_n;
   logic so, so_oe_n, miso, lk_sck, lk_fs, lk_mosi;
   logic [7:0] addr, got;
   logic [31:0] wdata, rdata, d, mask;
   logic [15:0] prx;
   logic [4:0] n;
   logic [1:0] md;
   int errors, total_checks, rises, edges, k;
   // The pad enables pick who owns each shared wire.
   wire sck_w = sck_oe_n ? lk_sck : sck_o;
   wire fs_w = fs_oe_n ? lk_fs : fs_o;
   wire si_w = sck_oe_n ? lk_mosi : miso;
   spi_frame_port spi_frame_port_inst (.sys_clk(sys_clk), .rst_n(rst_n),
      .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rdata(rdata), .serial_bit_clock_in(sck_w),
      .serial_bit_clock_out(sck_o), .serial_bit_clock_oe_n(sck_oe_n),
      .frame_select_in(fs_w), .frame_select_out(fs_o),
      .frame_select_oe_n(fs_oe_n), .serial_out(so),
      .serial_out_oe_n(so_oe_n), .serial_in(si_w));
   spi_slave_model spi_slave_model_inst (.sck(sck_w), .fs_n(fs_w),
      .mosi(so), .mode(md), .n(n), .miso(miso), .rx(prx), .edges(edges));
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge fs_w) rises++;
   task automatic chk(input string nm, input logic [31:0] s, e);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      addr <= a;
      wdata <= v;
      wr_stb <= 1'b1;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // --------------------------------------------------------------------
   // Four modes with two words each, then one slave frame.
   // --------------------------------------------------------------------
   initial begin
      {sys_clk, rst_n, wr_stb, rd_stb, lk_sck, lk_mosi, addr, wdata} = '0;
      {n, md, lk_fs} = '1;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      chk("reset pins", {fs_o, sck_o, so, sck_oe_n, fs_oe_n, so_oe_n}, 6'h27);
      rd(8'h10, d);
      chk("unmapped", d, 32'h0);
      wr(8'h00, 32'h10);
      rd(8'h00, d);
      chk("size clamp", d, 32'h30);
      for (int m = 0; m < 4; m++) begin
         md = m[1:0];
         n = NS[m];
         mask = (32'h1 << n) - 32'h1;
         wr(8'h00, {24'h0, 4'(n - 5'd1), md, 2'b10});
         repeat (3) @(posedge sys_clk);
         chk("idle", {fs_w, sck_w, so, sck_oe_n}, {1'b1, md[0], 2'b0});
         wr(8'h04, {16'h0, TXW});
         rises = 0;
         wr(8'h00, {24'h0, 4'(n - 5'd1), md, 2'b11});
         for (k = 0; fs_w !== 1'b0 && k < 100; k++) @(posedge sys_clk);
         chk("start", {fs_w, so_oe_n}, 32'h0);
         #152;
         chk("first edge", sck_w, md[0] ^ md[1]);
         chk("first bit", so, TXW[n - 5'd1]);
         wr(8'h04, {16'h0, TXW});
         k = 0;
         do begin
            rd(8'h0c, d);
            k++;
         end while (d[1:0] !== 2'b00 && k < 2000);
         chk("poll done", d[1:0], 2'b00);
         chk("end idle", {fs_w, sck_w}, {1'b1, md[0]});
         chk("select rises", rises, md[1] ? 1 : 2);
         chk("edges", edges, md[1] ? 2 * n : n);
         chk("far rx", prx & mask, TXW & mask);
         rd(8'h08, d);
         chk("rx", d & mask, SW & mask);
      end
      // Slave frame on the link clock, 64 ns period, mode 0, 8 bits.
      wr(8'h00, 32'h71);
      wr(8'h04, 32'ha6);
      #13 lk_fs = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         lk_mosi = TXW[i];
         #32 lk_sck = 1'b1;
         got = {got[6:0], so};
         #32 lk_sck = 1'b0;
      end
      chk("slave pads", {sck_oe_n, so_oe_n}, 2'b10);
      lk_fs = 1'b1;
      lk_mosi = ~lk_mosi;
      repeat (40) @(posedge sys_clk);
      rd(8'h08, d);
      chk("slave rx", d[7:0], TXW[7:0]);
      chk("slave tx", got, 8'ha6);
      give_verdict();
   end
   // The whole run needs well under a tenth of this span.
   initial begin
      #400000;
      errors++;
      give_verdict();
   end
endmodule
